// [rtl/pemc_motor_unit.sv]
// Motor drive units: three 2-phase steppers, developer and fuser brushless motors.
// Assumes every controller line is synchronous to mclk and already debounced.
`timescale 1ns/1ns
// Overview of operation
// - Steppers follow step clock; monitor echoes it
// - Developer mode low colour, high black
// - Colour uses external reference; black internal
// - Compare feedback to reference, adjust commutation
// - Within 6.25 percent: status low, LED on
// - Developer runs while run_n low
// - Fuser runs while run_n low
// - Slow select low gives quarter fuser speed
module pemc_motor_unit #(
    parameter int unsigned DEV_REF_HALF = pemc_pkg::DEV_REF_HALF_CYC // Internal ref half period
) (
    input  wire logic                      mclk,                   // 250 MHz clock
    input  wire logic                      rst_n,                  // Async reset, active low
    input  wire logic                      step_control_clock,     // Step clock from controller
    input  wire logic                      color_drum_direction,   // Colour drum direction
    input  wire logic                      black_drum_direction,   // Black drum direction
    input  wire logic                      belt_motor_direction,   // Belt motor direction
    input  wire logic                      excite_pattern_a,       // Excitation select, bit 0
    input  wire logic                      excite_pattern_b,       // Excitation select, bit 1
    input  wire logic                      excite_wedge_select,    // Reduced-current select
    input  wire logic                      door_stop,              // High while a door is open
    input  wire logic                      developer_ref_clock,    // Colour developer reference
    input  wire logic                      developer_run_n,        // Developer on, active low
    input  wire logic                      developer_mode_select,  // Low colour, high black
    input  wire logic                      developer_fb_pulse,     // Developer speed feedback
    input  wire logic                      fuser_ref_clock,        // Fuser reference clock
    input  wire logic                      fuser_run_n,            // Fuser on, active low
    input  wire logic                      fuser_slow_select_n,    // Quarter speed, active low
    input  wire logic                      fuser_fb_pulse,         // Fuser speed feedback
    output logic                           step_clock_monitor,     // Registered step clock echo
    output logic [3:0]                     color_drum_coils,       // {A+,A-,B+,B-} drivers
    output logic [3:0]                     black_drum_coils,       // {A+,A-,B+,B-} drivers
    output logic [3:0]                     belt_motor_coils,       // {A+,A-,B+,B-} drivers
    output logic                           stepper_current_reduce, // Wedge reduced current
    output logic [pemc_pkg::DRV_W-1:0]     developer_drive_level,  // Developer advance level
    output logic                           developer_color_active, // Colour train selected
    output logic                           developer_lock_n,       // Speed lock, active low
    output logic                           lock_indicator_led,     // Lit while locked
    output logic [pemc_pkg::DRV_W-1:0]     fuser_drive_level,      // Fuser advance level
    output logic                           fuser_lock              // Fuser inside window
);
    import pemc_pkg::*;

    // All three steppers share the step clock and the mode lines,
    // so the sequencers differ only in their direction line.
    // Positions wrap round the eight table entries either way.

    // Half-step table: even entries one coil, odd entries two coils
    localparam logic [3:0] COIL_TABLE [8] = '{
        4'h8, 4'hA, 4'h2, 4'h6, 4'h4, 4'h5, 4'h1, 4'h9
    };
    // Last count of the internal divider, one half period
    localparam logic [PER_W-1:0] HALF_LAST = PER_W'(DEV_REF_HALF - 1);

    // Stepper, internal reference and developer mode state
    logic                           step_prev_ff;     // Step clock history
    logic [POS_W-1:0]               pos_ff [NUM_STEPPERS]; // Sequencer positions
    logic [3:0]                     coil_ff [NUM_STEPPERS]; // Registered coil drives
    logic                           wedge_ff;         // Registered current reduce
    logic [PER_W-1:0]               iref_cnt_ff;      // Internal reference divider
    logic                           iref_ff;          // Internal reference level
    logic                           mode_ff;          // Registered developer mode

    // Step clock edge, mode decode, per-motor direction
    wire        step_edge = step_control_clock & ~step_prev_ff;
    pemc_exc_t  exc_mode;
    assign exc_mode = pemc_exc_t'({excite_pattern_b, excite_pattern_a});
    // Direction vector, indexed like the sequencers below
    wire [NUM_STEPPERS-1:0] dir_vec = {belt_motor_direction,
                                       black_drum_direction,
                                       color_drum_direction};
    // Stepping is frozen while a door is open or in the hold mode
    // A lost step is not queued; the controller must send it again
    wire        step_go = step_edge & ~door_stop & (exc_mode != PEMC_EXC_HOLD);
    logic [POS_W-1:0] step_inc;

    // Step size follows the excitation mode
    always_comb begin
        // Every code is legal, so no default branch
        unique case (exc_mode)
            PEMC_EXC_HALF: step_inc = POS_W'(1);
            PEMC_EXC_HOLD: step_inc = POS_W'(0);
            PEMC_EXC_TWO_PHASE,
            PEMC_EXC_ONE_PHASE: step_inc = POS_W'(2);
        endcase
    end

    // Step clock echo, so the controller can see the clock arrive
    // The same flop is the edge detector's history
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            step_prev_ff <= 1'b0;
        end else begin
            step_prev_ff <= step_control_clock;
        end
    end
    assign step_clock_monitor = step_prev_ff;

    // One sequencer per stepping motor
    // Index 0 colour drum, 1 black drum, 2 belt
    genvar gi;
    generate
        for (gi = 0; gi < NUM_STEPPERS; gi++) begin : g_step
            wire [POS_W-1:0] moved   = dir_vec[gi] ? pos_ff[gi] - step_inc
                                                   : pos_ff[gi] + step_inc;
            // Stepping moves the position only on an accepted step
            wire [POS_W-1:0] stepped = step_go ? moved : pos_ff[gi];
            // Full-step modes pin the position parity to pick one or two coils
            wire [POS_W-1:0] nxt_pos =
                (exc_mode == PEMC_EXC_TWO_PHASE) ? (stepped | POS_W'(1)) :
                (exc_mode == PEMC_EXC_ONE_PHASE) ? (stepped & ~POS_W'(1)) :
                stepped;
            // Open door releases all coils so the motor cannot be driven
            wire [3:0]       nxt_coil = door_stop ? COIL_OFF : COIL_TABLE[nxt_pos];

            // Position and coil registers
            always_ff @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    pos_ff[gi]  <= POS_RST;
                    coil_ff[gi] <= COIL_OFF;
                end else begin
                    pos_ff[gi]  <= nxt_pos;
                    coil_ff[gi] <= nxt_coil;
                end
            end
        end
    endgenerate

    // Coil drives leave straight from flops, so they never glitch
    // while the table lookup settles
    assign color_drum_coils = coil_ff[0];
    assign black_drum_coils = coil_ff[1];
    assign belt_motor_coils = coil_ff[2];

    // Wedge lowers holding current; registered to keep the output glitch free
    // It scales current only and never alters the coil pattern
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wedge_ff <= 1'b0;
        end else begin
            wedge_ff <= excite_wedge_select;
        end
    end
    assign stepper_current_reduce = wedge_ff;

    // Black developer makes its own reference; runs free so lock is quick
    // Limitation: its phase is not tied to the external line, so a
    // switch from colour to black has to earn lock again
    wire iref_wrap = (iref_cnt_ff == HALF_LAST);
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            iref_cnt_ff <= '0;
            iref_ff     <= 1'b0;
        end else if (iref_wrap) begin
            // Toggle and restart at the end count
            iref_cnt_ff <= '0;
            iref_ff     <= ~iref_ff;
        end else begin
            iref_cnt_ff <= iref_cnt_ff + PER_W'(1);
        end
    end

    // Developer mode: low colour with external reference, high black with own
    // The source mux switches at once; the regulator may see one stray
    // period and then relocks
    wire dev_black = developer_mode_select;
    wire dev_ref   = dev_black ? iref_ff : developer_ref_clock;
    wire dev_run   = ~developer_run_n;
    wire dev_lock;

    // Mode echo, registered like the other status outputs
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mode_ff <= 1'b0;
        end else begin
            mode_ff <= ~dev_black;
        end
    end
    assign developer_color_active = mode_ff;

    // Developer regulator; a mode change restarts lock through period refresh
    pemc_speed_reg u_dev_reg (
        .mclk        (mclk),
        .rst_n       (rst_n),
        .run         (dev_run),
        .scale       (SCALE_NORMAL),
        .ref_clk     (dev_ref),
        .fb_pulse    (developer_fb_pulse),
        .drive_level (developer_drive_level),
        .locked      (dev_lock)
    );
    // Lock shows low on the status line and high on the lamp
    assign developer_lock_n   = ~dev_lock;
    assign lock_indicator_led = dev_lock;

    // Fuser: slow select stretches the target period four times
    // The reference line keeps its normal rate in slow mode
    wire       fus_run   = ~fuser_run_n;
    wire [1:0] fus_scale = fuser_slow_select_n ? SCALE_NORMAL : SCALE_QUARTER;

    // Fuser regulator, same logic as the developer's
    pemc_speed_reg u_fus_reg (
        .mclk        (mclk),
        .rst_n       (rst_n),
        .run         (fus_run),
        .scale       (fus_scale),
        .ref_clk     (fuser_ref_clock),
        .fb_pulse    (fuser_fb_pulse),
        .drive_level (fuser_drive_level),
        .locked      (fuser_lock)
    );
    // The fuser has no lamp; only its lock port reports
endmodule

// [rtl/pemc_pkg.sv]
// Shared constants for the print engine motor drive logic.
// Assumes a single 250 MHz clock; all controller lines are synchronous to it.
package pemc_pkg;

    // Clock and reference frequencies
    localparam int unsigned CLK_HZ        = 250_000_000;  // mclk rate
    localparam int unsigned DEV_REF_HZ    = 420;          // Developer reference clock
    localparam int unsigned FUSER_REF_HZ  = 1087;         // Fuser reference, made by controller
    // Half period of the black developer's own reference, rounded down
    localparam int unsigned DEV_REF_HALF_CYC = CLK_HZ / (2 * DEV_REF_HZ);

    // Period measurement and drive widths
    localparam int unsigned PER_W = 24;                   // Holds 4x the slowest period
    localparam int unsigned DRV_W = 8;                    // Commutation advance level
    localparam logic [PER_W-1:0] PER_MAX = 24'hFFFFFF;    // Counter saturation value
    localparam logic [DRV_W-1:0] DRV_MAX = 8'hFF;         // Drive saturation value
    localparam logic [DRV_W-1:0] DRV_RST = 8'h00;         // Drive level after reset
    localparam int unsigned LOCK_TOL_SHIFT = 4;           // 1/16 = 6.25 percent window
    localparam logic [1:0]  SCALE_NORMAL   = 2'h0;        // Target period = reference
    localparam logic [1:0]  SCALE_QUARTER  = 2'h2;        // Target period x4 = quarter speed

    // Stepper sequencer
    localparam int unsigned NUM_STEPPERS = 3;             // Colour drum, black drum, belt
    localparam int unsigned POS_W        = 3;             // Eight half-step positions
    localparam logic [POS_W-1:0] POS_RST = 3'h0;          // Position after reset
    localparam logic [3:0]  COIL_OFF     = 4'h0;          // All coil drivers released

    // Excitation modes, from {excite_pattern_b, excite_pattern_a}
    typedef enum logic [1:0] {
        PEMC_EXC_TWO_PHASE = 2'h0,                        // Full step, two coils on
        PEMC_EXC_HALF      = 2'h1,                        // Half step
        PEMC_EXC_ONE_PHASE = 2'h2,                        // Full step, one coil on
        PEMC_EXC_HOLD      = 2'h3                         // Energised, no stepping
    } pemc_exc_t;

endpackage

// [rtl/pemc_speed_reg.sv]
// Speed regulator for one brushless motor unit.
// Assumes reference and feedback pulses are clean, synchronous levels.
`timescale 1ns/1ns
module pemc_speed_reg (
    input  wire logic                        mclk,        // 250 MHz clock
    input  wire logic                        rst_n,       // Async reset, active low
    input  wire logic                        run,         // Motor commanded on
    input  wire logic [1:0]                  scale,       // Target period shift
    input  wire logic                        ref_clk,     // Reference clock level
    input  wire logic                        fb_pulse,    // Speed feedback pulse level
    output logic [pemc_pkg::DRV_W-1:0]       drive_level, // Commutation advance
    output logic                             locked       // Period inside window
);
    import pemc_pkg::*;

    logic             ref_prev_ff, fb_prev_ff;            // Edge history
    logic [PER_W-1:0] ref_cnt_ff, fb_cnt_ff;              // Running period counters
    logic [PER_W-1:0] ref_per_ff, fb_per_ff;              // Captured periods
    logic             ref_ok_ff, fb_ok_ff;                // A full period was seen
    logic [DRV_W-1:0] drv_ff;                             // Advance level
    logic             lock_ff;                            // Registered lock

    // Rising edges and the comparison window
    wire              ref_edge = ref_clk & ~ref_prev_ff;
    wire              fb_edge  = fb_pulse & ~fb_prev_ff;
    wire [PER_W-1:0]  target   = ref_per_ff << scale;      // Slow mode stretches target
    wire [PER_W-1:0]  tol      = target >> LOCK_TOL_SHIFT;
    wire [PER_W:0]    hi_lim   = {1'b0, target} + {1'b0, tol};
    wire [PER_W:0]    lo_lim   = {1'b0, target} - {1'b0, tol};
    wire              valid    = ref_ok_ff & fb_ok_ff;
    wire              too_slow = valid & ({1'b0, fb_per_ff} > hi_lim);
    wire              too_fast = valid & ({1'b0, fb_per_ff} < lo_lim);
    wire [PER_W-1:0]  nxt_ref_cnt = ref_edge ? PER_W'(1) :
                                   (ref_cnt_ff == PER_MAX) ? PER_MAX : ref_cnt_ff + PER_W'(1);
    wire [PER_W-1:0]  nxt_fb_cnt  = fb_edge ? PER_W'(1) :
                                   (fb_cnt_ff == PER_MAX) ? PER_MAX : fb_cnt_ff + PER_W'(1);
    // Advance up when slow, down when fast, saturating at both ends
    wire [DRV_W-1:0]  nxt_drv  = !run ? DRV_RST :
                                 (too_slow && drv_ff != DRV_MAX) ? drv_ff + DRV_W'(1) :
                                 (too_fast && drv_ff != DRV_RST) ? drv_ff - DRV_W'(1) : drv_ff;

    // Edge history and counters
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ref_prev_ff <= 1'b0;
            fb_prev_ff  <= 1'b0;
            ref_cnt_ff  <= '0;
            fb_cnt_ff   <= '0;
        end else begin
            ref_prev_ff <= ref_clk;
            fb_prev_ff  <= fb_pulse;
            ref_cnt_ff  <= nxt_ref_cnt;
            fb_cnt_ff   <= nxt_fb_cnt;
        end
    end

    // Period capture; a stopped motor forgets old periods so lock is re-earned
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ref_per_ff <= '0;
            fb_per_ff  <= '0;
            ref_ok_ff  <= 1'b0;
            fb_ok_ff   <= 1'b0;
        end else if (!run) begin
            ref_ok_ff  <= 1'b0;
            fb_ok_ff   <= 1'b0;
        end else begin
            if (ref_edge && ref_cnt_ff != '0) begin
                ref_per_ff <= ref_cnt_ff;
                ref_ok_ff  <= 1'b1;
            end
            if (fb_edge && fb_cnt_ff != '0) begin
                fb_per_ff  <= fb_cnt_ff;
                fb_ok_ff   <= 1'b1;
            end
        end
    end

    // Commutation advance and lock flag
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            drv_ff  <= DRV_RST;
            lock_ff <= 1'b0;
        end else begin
            drv_ff  <= nxt_drv;
            lock_ff <= run & valid & ~too_slow & ~too_fast;
        end
    end

    assign drive_level = drv_ff;
    assign locked      = lock_ff;
endmodule

// [test/pemc_ctrl_model.sv]
// Controller-side line source: reference clocks and feedback pulse trains.
// Assumes the bench gives even periods in mclk cycles; zero parks a line low.
`timescale 1ns/1ns
module pemc_ctrl_model (
    input  wire logic  mclk,     // Bench clock
    input  int         per [4],  // Dev ref, dev fb, fuser ref, fuser fb periods
    output logic [3:0] lvl       // Line levels, same order
);
    int cnt [4] = '{0, 0, 0, 0}; // Half-period counters
    initial lvl = 4'h0;
    // Toggle at half period; a parked line stays low, never holds a stale level
    always @(posedge mclk) begin
        for (int i = 0; i < 4; i++) begin
            if (per[i] == 0) begin
                lvl[i] <= 1'b0;
                cnt[i] <= 0;
            end else if (cnt[i] >= per[i] / 2 - 1) begin
                lvl[i] <= ~lvl[i];
                cnt[i] <= 0;
            end else begin
                cnt[i] <= cnt[i] + 1;
            end
        end
    end
endmodule

// [test/pemc_motor_unit_properties.sv]
// Concurrent checks on the motor unit's ports, bound into every instance.
// Assumes one mclk domain and the asynchronous active-low rst_n.
`timescale 1ns/1ns
module pemc_motor_unit_properties (
    input wire logic                        mclk,                   // Clock
    input wire logic                        rst_n,                  // Reset, active low
    input wire logic                        step_control_clock,     // Step clock level
    input wire logic                        excite_pattern_a,       // Mode bit 0
    input wire logic                        excite_pattern_b,       // Mode bit 1
    input wire logic                        excite_wedge_select,    // Wedge level
    input wire logic                        door_stop,              // Door open
    input wire logic                        developer_run_n,        // Developer on, low
    input wire logic                        developer_mode_select,  // Low colour
    input wire logic                        fuser_run_n,            // Fuser on, low
    input wire logic                        step_clock_monitor,     // Step clock echo
    input wire logic [3:0]                  color_drum_coils,       // Colour drum coils
    input wire logic [3:0]                  black_drum_coils,       // Black drum coils
    input wire logic [3:0]                  belt_motor_coils,       // Belt coils
    input wire logic                        stepper_current_reduce, // Wedge copy
    input wire logic [pemc_pkg::DRV_W-1:0]  developer_drive_level,  // Developer drive
    input wire logic                        developer_color_active, // Colour selected
    input wire logic                        developer_lock_n,       // Lock, active low
    input wire logic                        lock_indicator_led,     // Lock lamp
    input wire logic [pemc_pkg::DRV_W-1:0]  fuser_drive_level,      // Fuser drive
    input wire logic                        fuser_lock              // Fuser lock
);
    import pemc_pkg::*;
    // Single domain, so clock and disable are given once
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    // Echoes are only judged once the input has been steady for a cycle
    // and the flops have left reset, since they still hold reset values then
    monitor_echo_a: assert property (
        $past(rst_n) && $stable(step_control_clock) |->
        step_clock_monitor == step_control_clock)
        else $error("step monitor mismatch");
    wedge_copy_a: assert property (
        $past(rst_n) && $stable(excite_wedge_select) |->
        stepper_current_reduce == excite_wedge_select)
        else $error("wedge copy mismatch");
    hold_mode_a: assert property (
        (excite_pattern_a && excite_pattern_b && !door_stop)[*2] |=>
        $stable(color_drum_coils) && $stable(black_drum_coils) && $stable(belt_motor_coils))
        else $error("coils moved in hold");
    door_coils_a: assert property (
        door_stop |=> color_drum_coils == COIL_OFF && black_drum_coils == COIL_OFF &&
        belt_motor_coils == COIL_OFF)
        else $error("coils live with door open");
    dev_mode_a: assert property (
        $past(rst_n) && $stable(developer_mode_select) |->
        developer_color_active != developer_mode_select)
        else $error("development mode wrong");
    // Lamp and status are complements, and lock is only shown while running
    lock_pair_a: assert property (
        developer_lock_n != lock_indicator_led &&
        (!lock_indicator_led || !$past(developer_run_n)))
        else $error("lock status shown wrong");
    // Drive level slews by one step at most while running
    drive_slew_a: assert property (
        (!developer_run_n)[*2] |->
        developer_drive_level <= $past(developer_drive_level) + 1 &&
        developer_drive_level + 1 >= $past(developer_drive_level))
        else $error("drive jumped");
    dev_stop_a: assert property (
        developer_run_n |=> developer_drive_level == DRV_RST && developer_lock_n)
        else $error("developer still driven");
    fuser_stop_a: assert property (
        fuser_run_n |=> fuser_drive_level == DRV_RST && !fuser_lock)
        else $error("fuser still driven");
endmodule
bind pemc_motor_unit pemc_motor_unit_properties chk_i (.*);

// [test/tb_top.sv]
// Self-checking bench for the motor unit, with the controller line model.
// Assumes the checker is bound in; inputs change at rising edges only.
`timescale 1ns/1ns
module tb_top;
    import pemc_pkg::*;
    localparam int unsigned HALF = 8; // Shortened internal reference half period
    logic mclk = 1'b0, rst_n = 1'b0, step_control_clock = 1'b0, excite_wedge_select = 1'b0;
    logic color_drum_direction = 1'b0, black_drum_direction = 1'b1, door_stop = 1'b0;
    logic belt_motor_direction = 1'b0, excite_pattern_a = 1'b0, excite_pattern_b = 1'b0;
    logic developer_run_n = 1'b1, developer_mode_select = 1'b0, fuser_slow_select_n = 1'b1;
    logic fuser_run_n = 1'b1, developer_ref_clock, developer_fb_pulse, fuser_ref_clock;
    logic fuser_fb_pulse, step_clock_monitor, stepper_current_reduce, developer_color_active;
    logic developer_lock_n, lock_indicator_led, fuser_lock;
    logic [3:0]       lvl, color_drum_coils, black_drum_coils, belt_motor_coils;
    logic [DRV_W-1:0] developer_drive_level, fuser_drive_level;
    int               per [4] = '{0, 0, 0, 0};            // Partner periods
    int               n_mismatch = 0, comparisons = 0, cycles = 0;

    assign {fuser_fb_pulse, fuser_ref_clock, developer_fb_pulse, developer_ref_clock} = lvl;
    pemc_motor_unit #(.DEV_REF_HALF(HALF)) uut (.*);
    pemc_ctrl_model ctrl (.mclk(mclk), .per(per), .lvl(lvl));
    always #2 mclk = ~mclk;                                // 250 MHz

    // Hang guard: well above the run's few thousand cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            close_out();
        end
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        if (n_mismatch == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // One step pulse, low and high for two cycles each
    task automatic step_once();
        @(posedge mclk) step_control_clock <= 1'b1;
        @(negedge mclk);
        @(negedge mclk) chk(step_clock_monitor, 1'b1);
        @(posedge mclk) step_control_clock <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask

    task automatic coils(input logic [3:0] c, input logic [3:0] k, input logic [3:0] t);
        @(negedge mclk);
        chk(color_drum_coils, c);
        chk(black_drum_coils, k);
        chk(belt_motor_coils, t);
    endtask

    task automatic set_mode(input logic b, input logic a);
        @(posedge mclk) {excite_pattern_b, excite_pattern_a} <= {b, a};
        repeat (2) @(posedge mclk);
    endtask

    // Directions differ per motor; step size and hold follow the mode lines
    task automatic t_stepper();
        coils(4'hA, 4'hA, 4'hA);               // Two-phase start on position 1
        step_once();
        coils(4'h6, 4'h9, 4'h6);
        set_mode(1'b0, 1'b1);                  // Half step
        step_once();
        coils(4'h4, 4'h1, 4'h4);
        set_mode(1'b1, 1'b0);                  // One-phase full step
        step_once();
        coils(4'h1, 4'h4, 4'h1);
        set_mode(1'b1, 1'b1);                  // Hold: step ignored
        step_once();
        coils(4'h1, 4'h4, 4'h1);
        @(posedge mclk) excite_wedge_select <= 1'b1;
        repeat (2) @(negedge mclk);
        chk(stepper_current_reduce, 1'b1);
        set_mode(1'b1, 1'b0);
        @(posedge mclk) door_stop <= 1'b1;
        step_once();                           // Lost while the door is open
        coils(4'h0, 4'h0, 4'h0);
        @(posedge mclk) door_stop <= 1'b0;
        repeat (2) @(posedge mclk);
        coils(4'h1, 4'h4, 4'h1);
    endtask

    // Colour developer: lock at the window edge, loss outside, stop
    task automatic t_dev_color();
        @(posedge mclk) per <= '{32, 32, 0, 0};
        developer_run_n <= 1'b0;
        repeat (200) @(negedge mclk);
        chk(developer_lock_n, 1'b0);
        chk(lock_indicator_led, 1'b1);
        chk(developer_color_active, 1'b1);
        @(posedge mclk) per[1] <= 36;          // Four cycles off, window is two
        repeat (200) @(negedge mclk);
        chk(developer_lock_n, 1'b1);
        chk(developer_drive_level != DRV_RST, 1'b1);
        @(posedge mclk) per[1] <= 34;          // Exactly on the window bound
        repeat (200) @(negedge mclk);
        chk(developer_lock_n, 1'b0);
        @(posedge mclk) developer_run_n <= 1'b1;
        repeat (2) @(negedge mclk);
        chk(developer_drive_level, DRV_RST);
        chk(developer_lock_n, 1'b1);
    endtask

    // Black developer ignores the external line and locks to its own reference
    task automatic t_dev_black();
        @(posedge mclk) per <= '{40, 2 * HALF, 0, 0};
        developer_mode_select <= 1'b1;
        developer_run_n <= 1'b0;
        repeat (300) @(negedge mclk);
        chk(developer_lock_n, 1'b0);
        chk(developer_color_active, 1'b0);
    endtask

    // Fuser at quarter speed, then normal speed, then stopped
    task automatic t_fuser();
        @(posedge mclk) per <= '{0, 0, 20, 80};
        fuser_slow_select_n <= 1'b0;
        fuser_run_n <= 1'b0;
        repeat (400) @(negedge mclk);
        chk(fuser_lock, 1'b1);
        @(posedge mclk) fuser_slow_select_n <= 1'b1;
        repeat (400) @(negedge mclk);
        chk(fuser_lock, 1'b0);
        @(posedge mclk) per[3] <= 20;
        repeat (300) @(negedge mclk);
        chk(fuser_lock, 1'b1);
        @(posedge mclk) fuser_run_n <= 1'b1;
        repeat (2) @(negedge mclk);
        chk(fuser_drive_level, DRV_RST);
        chk(fuser_lock, 1'b0);
    endtask

    // Main sequence: reset, then each scenario in turn
    initial begin
        repeat (7) @(posedge mclk);
        @(negedge mclk) chk(developer_lock_n, 1'b1);
        @(posedge mclk) rst_n <= 1'b1;
        @(posedge mclk);                       // First edge out of reset loads the coils
        t_stepper();
        t_dev_color();
        t_dev_black();
        t_fuser();
        close_out();
    end
endmodule
